/* rbdc_core.sv */
// Receive baseband digital control: register port, dividers, error estimator, bit sync
`timescale 1ns/100ps
`default_nettype none
`include "rbdc_regs.svh"

// Notes on behaviour
// - Filter clock from crystal via 6-bit divider
// - Divided again by four into phases
// - Up pulse per one, down per zero
// - Mode 00 off, 11 counts up/down
// - Symbol count selected by two-bit field
// - Eight-bit error readable at its address
// - Register load clears counter, then counts
// - Value is two's complement
// - Counter wraps, never saturates
// - Bit sync only receive with sync set
// - Recovered clock equals the bit rate
// - Data changes on data clock rising
// - Sync clock is reference over 2^(7-scale)
// - One reference divider shared by three clocks
// - Lock within 22 bits worst case
// - Level zero turns amplifier off
// - Bypass bit routes around amplifier
// - Filter register top two bits read one
module rbdc_core #(
  parameter int FIFO_W = 1,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic prog_clk_i,
  input wire logic prog_en_i,
  input wire logic prog_dat_i,
  output logic prog_dat_o,
  output logic prog_dat_oe_o,
  input wire logic demod_up_i,
  input wire logic demod_dn_i,
  input wire logic demod_data_i,
  input wire logic sym_strobe_i,
  output logic bit_clock_pin_o,
  output logic bit_clock_pin_oe_o,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  input wire logic serial_data_pin_i,
  output logic tx_data_o,
  output logic filter_phase1_o,
  output logic filter_phase2_o,
  output logic mod_clk_en_o,
  output logic pa_on_o,
  output logic [2:0] power_level_field_o,
  output logic amplifier_bypass_o,
  output logic low_noise_amp_skip_o,
  output logic signal_strength_enable_o,
  output logic bitsync_locked_o
);
  localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // Power-of-two tap: true when low (7-s) bits of the count are all ones
  function automatic logic scale_hit(input logic [6:0] cnt, input logic [2:0] s);
    logic [6:0] mask;
    mask = 7'h7F >> s;
    return (cnt & mask) == mask;
  endfunction

  // Register file
  rbdc_pkg::rbdc_mode_power_t mp_q, mp_d;
  logic [7:0] modrx_q, modrx_d, pump_q, pump_d, scl6_q, scl6_d, ref7_q, ref7_d;
  logic [7:0] filt_q, filt_d, error_estimator_control_q, error_estimator_control_d;
  // Serial port state
  rbdc_pkg::rbdc_sp_state_t sp_q, sp_d;
  logic [3:0] sp_cnt_q, sp_cnt_d;
  logic [15:0] sp_sh_q, sp_sh_d; // Address, R/W flag and data byte of one frame
  logic [7:0] rd_sh_q, rd_sh_d;
  logic pclk_prev_q, pclk_prev_d;
  logic pdat_o_q, pdat_o_d, pdat_oe_q, pdat_oe_d;
  logic load_q, load_d; // One-cycle pulse after a committed write
  logic [7:0] fee_q, fee_d;
  rbdc_pkg::rbdc_scales_t scl;

  logic pclk_rise;
  assign pclk_rise = prog_clk_i & ~pclk_prev_q;
  assign scl = '{mod_scale: scl6_q[6:4], bitsync_scale: scl6_q[3:1],
                 bitrate_scale: {scl6_q[0], ref7_q[7:6]}, ref_div: ref7_q[5:0]};

  // Read mux; unmapped addresses read zero
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    unique case (a)
      `RBDC_OFS_MODE_POWER: return mp_q;
      `RBDC_OFS_MOD_RX: return modrx_q;
      `RBDC_OFS_PUMP_BYPASS: return pump_q;
      `RBDC_OFS_CLK_SCALE: return scl6_q;
      `RBDC_OFS_REF_DIV: return ref7_q;
      `RBDC_OFS_FILTER_CLK: return filt_q | `RBDC_FILTER_FIXED;
      `RBDC_OFS_FEE_CTRL: return error_estimator_control_q & `RBDC_FEE_CTRL_MASK;
      `RBDC_OFS_FEE_RESULT: return fee_q;
      default: return 8'h00;
    endcase
  endfunction

  // Three-wire port: 7 address bits, R/W, 8 data bits, MSB first
  always_comb begin
    sp_d = sp_q;
    sp_cnt_d = sp_cnt_q;
    sp_sh_d = sp_sh_q;
    rd_sh_d = rd_sh_q;
    pclk_prev_d = prog_clk_i;
    pdat_o_d = pdat_o_q;
    pdat_oe_d = pdat_oe_q;
    load_d = 1'b0;
    mp_d = mp_q;
    modrx_d = modrx_q;
    pump_d = pump_q;
    scl6_d = scl6_q;
    ref7_d = ref7_q;
    filt_d = filt_q;
    error_estimator_control_d = error_estimator_control_q;
    unique case (sp_q)
      rbdc_pkg::SP_IDLE: begin
        pdat_oe_d = 1'b0;
        sp_cnt_d = 4'h0;
        if (prog_en_i) begin
          sp_d = rbdc_pkg::SP_SHIFT;
        end
      end
      rbdc_pkg::SP_SHIFT: begin
        if (!prog_en_i) begin
          // Aborted frame is dropped
          sp_d = rbdc_pkg::SP_IDLE;
        end else if (pclk_rise) begin
          sp_sh_d = {sp_sh_q[14:0], prog_dat_i};
          sp_cnt_d = sp_cnt_q + 4'h1;
          if (sp_cnt_q == `RBDC_RW_BIT && prog_dat_i) begin
            // Read: device drives data, changing on rising edges
            rd_sh_d = reg_read(sp_sh_q[6:0]);
            pdat_o_d = rd_sh_d[7];
            pdat_oe_d = 1'b1;
          end else if (pdat_oe_q) begin
            rd_sh_d = {rd_sh_q[6:0], 1'b0};
            pdat_o_d = rd_sh_q[6];
          end
          if (sp_cnt_q == `RBDC_FRAME_BITS) begin
            // Sixteenth bit closes the frame
            sp_d = rbdc_pkg::SP_DONE;
          end
        end
      end
      rbdc_pkg::SP_DONE: begin
        if (!prog_en_i) begin
          sp_d = rbdc_pkg::SP_IDLE;
          pdat_oe_d = 1'b0;
          if (!sp_sh_q[8]) begin
            load_d = 1'b1;
            unique case (sp_sh_q[15:9])
              `RBDC_OFS_MODE_POWER: mp_d = sp_sh_q[7:0];
              `RBDC_OFS_MOD_RX: modrx_d = sp_sh_q[7:0];
              `RBDC_OFS_PUMP_BYPASS: pump_d = sp_sh_q[7:0];
              `RBDC_OFS_CLK_SCALE: scl6_d = sp_sh_q[7:0];
              `RBDC_OFS_REF_DIV: ref7_d = sp_sh_q[7:0];
              `RBDC_OFS_FILTER_CLK: filt_d = sp_sh_q[7:0] | `RBDC_FILTER_FIXED;
              `RBDC_OFS_FEE_CTRL: error_estimator_control_d = sp_sh_q[7:0] & `RBDC_FEE_CTRL_MASK;
              default: ;
            endcase
          end
        end
      end
      default: sp_d = rbdc_pkg::SP_IDLE;
    endcase
  end

  // Port and register flops
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_q <= rbdc_pkg::SP_IDLE;
      sp_cnt_q <= 4'h0;
      sp_sh_q <= 16'h0000;
      rd_sh_q <= 8'h00;
      pclk_prev_q <= 1'b0;
      pdat_o_q <= 1'b0;
      pdat_oe_q <= 1'b0;
      load_q <= 1'b0;
      mp_q <= `RBDC_RST_MODE_POWER;
      modrx_q <= `RBDC_RST_MOD_RX;
      pump_q <= `RBDC_RST_PUMP_BYPASS;
      scl6_q <= `RBDC_RST_CLK_SCALE;
      ref7_q <= `RBDC_RST_REF_DIV;
      filt_q <= `RBDC_RST_FILTER_CLK;
      error_estimator_control_q <= `RBDC_RST_FEE_CTRL;
    end else begin
      sp_q <= sp_d;
      sp_cnt_q <= sp_cnt_d;
      sp_sh_q <= sp_sh_d;
      rd_sh_q <= rd_sh_d;
      pclk_prev_q <= pclk_prev_d;
      pdat_o_q <= pdat_o_d;
      pdat_oe_q <= pdat_oe_d;
      load_q <= load_d;
      mp_q <= mp_d;
      modrx_q <= modrx_d;
      pump_q <= pump_d;
      scl6_q <= scl6_d;
      ref7_q <= ref7_d;
      filt_q <= filt_d;
      error_estimator_control_q <= error_estimator_control_d;
    end
  end
  assign prog_dat_o = pdat_o_q;
  assign prog_dat_oe_o = pdat_oe_q;

  // Dividers: filter clock, shared reference and its power-of-two taps
  logic [5:0] fdiv_q, fdiv_d, rdiv_q, rdiv_d;
  logic [1:0] fph_q, fph_d;
  logic [6:0] rcnt_q, rcnt_d;
  logic ref_tick, bs_tick, mod_tick, br_tick;
  logic ph1_q, ph1_d, ph2_q, ph2_d, modt_q, modt_d;
  // Divider value 0 is treated as 1 so the chain never stops
  assign ref_tick = (scl.ref_div == 6'h00) || (rdiv_q >= scl.ref_div - 6'h01);
  assign bs_tick = ref_tick && scale_hit(rcnt_q, scl.bitsync_scale);
  assign mod_tick = ref_tick && scale_hit(rcnt_q, scl.mod_scale);
  assign br_tick = ref_tick && scale_hit(rcnt_q, scl.bitrate_scale + 3'h1);
  always_comb begin
    fdiv_d = fdiv_q + 6'h01;
    fph_d = fph_q;
    if (fdiv_q >= filt_q[5:0] - 6'h01 || filt_q[5:0] == 6'h00) begin
      fdiv_d = 6'h00;
      fph_d = fph_q + 2'h1;
    end
    // Two phases, each high one quarter, never together
    ph1_d = (fph_q == 2'h0);
    ph2_d = (fph_q == 2'h2);
    rdiv_d = ref_tick ? 6'h00 : rdiv_q + 6'h01;
    rcnt_d = ref_tick ? rcnt_q + 7'h01 : rcnt_q;
    modt_d = mod_tick;
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fdiv_q <= 6'h00;
      fph_q <= 2'h0;
      rdiv_q <= 6'h00;
      rcnt_q <= 7'h00;
      ph1_q <= 1'b0;
      ph2_q <= 1'b0;
      modt_q <= 1'b0;
    end else begin
      fdiv_q <= fdiv_d;
      fph_q <= fph_d;
      rdiv_q <= rdiv_d;
      rcnt_q <= rcnt_d;
      ph1_q <= ph1_d;
      ph2_q <= ph2_d;
      modt_q <= modt_d;
    end
  end
  assign filter_phase1_o = ph1_q;
  assign filter_phase2_o = ph2_q;
  assign mod_clk_en_o = modt_q;

  // Frequency error estimator
  logic [6:0] sym_q, sym_d;
  logic fdone_q, fdone_d;
  logic [6:0] sym_target;
  assign sym_target = 7'(`RBDC_SYM_BASE << error_estimator_control_q[3:2]);
  always_comb begin
    fee_d = fee_q;
    sym_d = sym_q;
    fdone_d = fdone_q;
    if (load_q) begin
      fee_d = 8'h00;
      sym_d = 7'h00;
      fdone_d = 1'b0;
    end else if (error_estimator_control_q[1:0] == `RBDC_FEE_RUN && !fdone_q) begin
      // Plain 8-bit add so +127 rolls into the negative range
      if (demod_up_i && !demod_dn_i) begin
        fee_d = fee_q + 8'h01;
      end else if (demod_dn_i && !demod_up_i) begin
        fee_d = fee_q - 8'h01;
      end
      if (sym_strobe_i) begin
        sym_d = sym_q + 7'h01;
        fdone_d = (sym_q + 7'h01 == sym_target);
      end
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fee_q <= 8'h00;
      sym_q <= 7'h00;
      fdone_q <= 1'b0;
    end else begin
      fee_q <= fee_d;
      sym_q <= sym_d;
      fdone_q <= fdone_d;
    end
  end

  // Bit synchronizer with a small buffer between sampler and pin
  logic sync_rx;
  logic [3:0] phase_q, phase_d;
  logic prev_q, prev_d, pend_q, pend_d, pend_v_q, pend_v_d;
  logic [4:0] good_q, good_d;
  logic [FIFO_W-1:0] mem_q [FIFO_DEPTH];
  logic [FIFO_W-1:0] mem_d [FIFO_DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic in_valid, in_ready, out_valid, out_ready, clk_rise;
  logic dclk_q, dclk_d, sdo_q, sdo_d, sdo_oe_q, sdo_oe_d, dclk_oe_q, dclk_oe_d;
  logic txd_q, txd_d, brclk_q, brclk_d;
  assign sync_rx = mp_q.sync_en && (mp_q.mode == rbdc_pkg::MODE_RECEIVE);
  assign in_valid = pend_v_q;
  assign in_ready = (cnt_q != (AW+1)'(FIFO_DEPTH));
  assign out_valid = (cnt_q != '0);
  assign clk_rise = sync_rx && bs_tick && phase_q == 4'hF;
  assign out_ready = clk_rise; // Drain stalls between data clock edges
  always_comb begin
    phase_d = phase_q;
    prev_d = prev_q;
    pend_d = pend_q;
    pend_v_d = pend_v_q && !in_ready;
    good_d = good_q;
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (in_valid && in_ready) begin
      mem_d[wp_q] = FIFO_W'(pend_q);
      wp_d = (wp_q == AW'(FIFO_DEPTH - 1)) ? '0 : wp_q + AW'(1);
    end
    if (out_valid && out_ready) begin
      rp_d = (rp_q == AW'(FIFO_DEPTH - 1)) ? '0 : rp_q + AW'(1);
    end
    cnt_d = cnt_q + (AW+1)'(in_valid && in_ready) - (AW+1)'(out_valid && out_ready);
    if (!sync_rx) begin
      phase_d = 4'h0;
      good_d = 5'h00;
    end else if (bs_tick) begin
      prev_d = demod_data_i;
      phase_d = phase_q + 4'h1;
      if (demod_data_i != prev_q) begin
        // One step per edge: at most eight edges to pull in
        if (phase_q == 4'h0) begin
          good_d = (good_q == 5'h1F) ? good_q : good_q + 5'h01;
        end else begin
          good_d = 5'h00;
          phase_d = (phase_q < `RBDC_MID_PHASE) ? phase_q : phase_q + 4'h2;
        end
      end
      if (phase_q == `RBDC_MID_PHASE) begin
        pend_d = demod_data_i;
        pend_v_d = 1'b1; // A full buffer holds the sample here
      end
    end
    // Clock high in the first half of each bit: one period per bit
    dclk_d = sync_rx ? (phase_d < `RBDC_MID_PHASE) : brclk_q;
    dclk_oe_d = mp_q.sync_en;
    brclk_d = br_tick ? !brclk_q : brclk_q;
    sdo_d = sdo_q;
    if (clk_rise && out_valid) begin
      sdo_d = mem_q[rp_q][0];
    end else if (!mp_q.sync_en) begin
      sdo_d = demod_data_i; // Transparent receive
    end
    sdo_oe_d = (mp_q.mode == rbdc_pkg::MODE_RECEIVE);
    // Transmit sync: device samples host data on its rising clock
    txd_d = (br_tick && !brclk_q) || !mp_q.sync_en ? serial_data_pin_i : txd_q;
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_q <= 4'h0;
      prev_q <= 1'b0;
      pend_q <= 1'b0;
      pend_v_q <= 1'b0;
      good_q <= 5'h00;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      dclk_q <= 1'b0;
      dclk_oe_q <= 1'b0;
      brclk_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      txd_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      prev_q <= prev_d;
      pend_q <= pend_d;
      pend_v_q <= pend_v_d;
      good_q <= good_d;
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      dclk_q <= dclk_d;
      dclk_oe_q <= dclk_oe_d;
      brclk_q <= brclk_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
      txd_q <= txd_d;
    end
  end
  assign bit_clock_pin_o = dclk_q;
  assign bit_clock_pin_oe_o = dclk_oe_q;
  assign serial_data_pin_o = sdo_q;
  assign serial_data_pin_oe_o = sdo_oe_q;
  assign tx_data_o = txd_q;
  // Eight aligned edges, so worst pull-in plus lock stays inside 22 bits
  assign bitsync_locked_o = good_q[3];

  // Amplifier controls, registered
  rbdc_pkg::rbdc_pa_t pa_q, pa_d;
  logic lna_q, lna_d, rssi_q, rssi_d;
  always_comb begin
    pa_d.level = mp_q.power_level;
    pa_d.pa_on = (mp_q.power_level != 3'h0);
    pa_d.bypass = pump_q[4];
    lna_d = mp_q.lna_skip;
    rssi_d = modrx_q[3];
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pa_q <= '0;
      lna_q <= 1'b0;
      rssi_q <= 1'b0;
    end else begin
      pa_q <= pa_d;
      lna_q <= lna_d;
      rssi_q <= rssi_d;
    end
  end
  assign pa_on_o = pa_q.pa_on;
  assign power_level_field_o = pa_q.level;
  assign amplifier_bypass_o = pa_q.bypass;
  assign low_noise_amp_skip_o = lna_q;
  assign signal_strength_enable_o = rssi_q;

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_fee_clear_load: assert property (load_q |=> fee_q == 8'h00)
    else $error("error counter not cleared by load");
  a_fee_off_hold: assert property (!load_q && error_estimator_control_q[1:0] != 2'h3 |=> $stable(fee_q))
    else $error("error counter moved while off");
  a_fee_up_count: assert property (!load_q && error_estimator_control_q[1:0] == 2'h3 && !fdone_q && demod_up_i
    && !demod_dn_i |=> fee_q == $past(fee_q) + 8'h01)
    else $error("up pulse not counted");
  a_fee_wrap_neg: assert property (!load_q && fee_q == 8'h7F && error_estimator_control_q[1:0] == 2'h3 && !fdone_q
    && demod_up_i && !demod_dn_i |=> fee_q == 8'h80)
    else $error("counter did not wrap");
  a_fee_done_hold: assert property (fdone_q && !load_q |=> $stable(fee_q))
    else $error("result moved after measurement");
  a_pa_off_zero: assert property (mp_q.power_level == 3'h0 |=> !pa_on_o)
    else $error("amplifier on at level zero");
  a_sync_only_rx: assert property (!sync_rx |=> phase_q == 4'h0)
    else $error("bit sync ran outside receive");
  a_data_on_rise: assert property ($changed(sdo_q) && sync_rx && $past(sync_rx)
    |-> $rose(dclk_q))
    else $error("data changed off the rising edge");
  a_fifo_bound: assert property (cnt_q <= (AW+1)'(FIFO_DEPTH))
    else $error("buffer overfilled");
  a_filter_fixed: assert property (filt_q[7:6] == 2'b11)
    else $error("filter register top bits lost");
  c_fee_done: cover property (fdone_q && fee_q != 8'h00);
  c_sync_lock: cover property (bitsync_locked_o);
  c_fifo_full: cover property (cnt_q == (AW+1)'(FIFO_DEPTH));
  c_reg_read: cover property (prog_dat_oe_o);
endmodule
`default_nettype wire

/* rbdc_regs.svh */
// Register offsets, field positions, reset values and counts of the receive baseband control
`ifndef RBDC_REGS_SVH
`define RBDC_REGS_SVH
`define RBDC_ADDR_W 7
`define RBDC_OFS_MODE_POWER 7'h00
`define RBDC_OFS_MOD_RX 7'h01
`define RBDC_OFS_PUMP_BYPASS 7'h02
`define RBDC_OFS_CLK_SCALE 7'h06
`define RBDC_OFS_REF_DIV 7'h07
`define RBDC_OFS_FILTER_CLK 7'h08
`define RBDC_OFS_FEE_CTRL 7'h15
`define RBDC_OFS_FEE_RESULT 7'h16
`define RBDC_RST_MODE_POWER 8'h00
`define RBDC_RST_MOD_RX 8'h00
`define RBDC_RST_PUMP_BYPASS 8'h00
`define RBDC_RST_CLK_SCALE 8'h00
`define RBDC_RST_REF_DIV 8'h01
`define RBDC_RST_FILTER_CLK 8'hC1
`define RBDC_RST_FEE_CTRL 8'h00
`define RBDC_FILTER_FIXED 8'hC0
`define RBDC_FEE_CTRL_MASK 8'h0F
`define RBDC_FEE_RUN 2'h3
`define RBDC_SYM_BASE 8'h08
`define RBDC_FILTER_PHASES 2'h3
`define RBDC_OVERSAMPLE 5'h10
`define RBDC_MID_PHASE 4'h8
`define RBDC_FRAME_BITS 4'hF
`define RBDC_ADDR_BITS 4'h7
`define RBDC_RW_BIT 4'h7
`endif

/* rbdc_pkg.sv */
// Types shared by the receive baseband control block
package rbdc_pkg;
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_STANDBY,
    MODE_RECEIVE,
    MODE_TRANSMIT
  } rbdc_mode_t;

  typedef enum logic [1:0] {
    SP_IDLE,
    SP_SHIFT,
    SP_DONE
  } rbdc_sp_state_t;

  // Fields of register 0
  typedef struct packed {
    logic lna_skip;
    logic [2:0] power_level;
    logic sync_en;
    logic [1:0] mode;
    logic load_en;
  } rbdc_mode_power_t;

  // Shared clock scale settings
  typedef struct packed {
    logic [2:0] mod_scale;
    logic [2:0] bitsync_scale;
    logic [2:0] bitrate_scale;
    logic [5:0] ref_div;
  } rbdc_scales_t;

  // Power amplifier controls
  typedef struct packed {
    logic pa_on;
    logic bypass;
    logic [2:0] level;
  } rbdc_pa_t;
endpackage

/* rbdc_host_model.sv */
// Host model: samples receive data on the falling data clock
`timescale 1ns/100ps
`default_nettype none
module rbdc_host_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic bit_clock_pin_i,
  input wire logic sync_on_i,
  input wire logic data_pin_i,
  input wire logic data_oe_i,
  output logic pin_to_dev_o,
  output logic [7:0] samples_o,
  output logic [1:0] last_bits_o,
  output logic [7:0] bad_edges_o
);
  logic clk_p_q; // Data clock one cycle back
  logic dat_p_q; // Data pin one cycle back
  logic rls_q; // Filler while released
  // No pull on the pin, so a released pin shows a changing level
  assign pin_to_dev_o = data_oe_i ? data_pin_i : rls_q;
  // Sample on falling clock, count data moves off the rising clock
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_p_q <= 1'b0;
      dat_p_q <= 1'b0;
      rls_q <= 1'b0;
      samples_o <= 8'h00;
      last_bits_o <= 2'h0;
      bad_edges_o <= 8'h00;
    end else begin
      clk_p_q <= bit_clock_pin_i;
      dat_p_q <= data_pin_i;
      rls_q <= ~rls_q;
      if (sync_on_i && clk_p_q && !bit_clock_pin_i) begin
        samples_o <= samples_o + 8'h01;
        last_bits_o <= {last_bits_o[0], data_pin_i};
      end
      if (sync_on_i && data_oe_i && (data_pin_i != dat_p_q) &&
          !(bit_clock_pin_i && !clk_p_q)) begin
        bad_edges_o <= bad_edges_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* rx_baseband_digital_control_tb.sv */
// Self-checking bench for the receive baseband control block
`timescale 1ns/100ps
`default_nettype none
module rx_baseband_digital_control_tb;
  logic clk, arst_n, pclk, pen, pdat, up, dn, ddat, sym, run_data; // Driven inputs
  logic p_do, p_oe, bck, bck_oe, sd, sd_oe, sd_in, txd, ph1, ph2, mclk; // Observed
  logic pa_on, byp, lna, rssi, lock;
  logic [2:0] lvl;
  logic [7:0] smp, bad;
  logic [1:0] lb;
  int fails, tests_run, ovl, dcnt;
  string nm_q[$]; // Pending check names
  logic [7:0] exp_q[$], got_q[$]; // Expected and seen values
  logic [6:0] ra[9] = '{7'h00, 7'h01, 7'h02, 7'h06, 7'h07, 7'h08, 7'h15, 7'h16, 7'h7F};
  logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hC1, 8'h00, 8'h00, 8'h00};
  logic [7:0] fd[4] = '{8'h01, 8'h05, 8'h3F, 8'h00}; // Filter divider values
  int fx[4] = '{4, 20, 252, 4}; // Phase periods, four divider ticks

  always #12.5 clk = ~clk;

  rbdc_core rbdc_core_inst (.clock_i(clk), .arst_n_i(arst_n), .prog_clk_i(pclk),
    .prog_en_i(pen), .prog_dat_i(pdat), .prog_dat_o(p_do), .prog_dat_oe_o(p_oe),
    .demod_up_i(up), .demod_dn_i(dn), .demod_data_i(ddat), .sym_strobe_i(sym),
    .bit_clock_pin_o(bck), .bit_clock_pin_oe_o(bck_oe), .serial_data_pin_o(sd),
    .serial_data_pin_oe_o(sd_oe), .serial_data_pin_i(sd_in), .tx_data_o(txd),
    .filter_phase1_o(ph1), .filter_phase2_o(ph2), .mod_clk_en_o(mclk), .pa_on_o(pa_on),
    .power_level_field_o(lvl), .amplifier_bypass_o(byp), .low_noise_amp_skip_o(lna),
    .signal_strength_enable_o(rssi), .bitsync_locked_o(lock));

  rbdc_host_model rbdc_host_model_inst (.clock_i(clk), .arst_n_i(arst_n),
    .bit_clock_pin_i(bck), .sync_on_i(bck_oe), .data_pin_i(sd), .data_oe_i(sd_oe),
    .pin_to_dev_o(sd_in), .samples_o(smp), .last_bits_o(lb), .bad_edges_o(bad));

  // Received data toggles once per 32-cycle bit
  always @(posedge clk) begin
    if (run_data) begin
      dcnt <= (dcnt == 31) ? 0 : dcnt + 1;
      if (dcnt == 31) ddat <= ~ddat;
    end
  end

  // Takes the oldest note whenever a result shows up
  always begin
    wait (got_q.size() > 0);
    tests_run++;
    if (got_q[0] !== exp_q[0]) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm_q[0], exp_q[0], got_q[0]);
    end
    void'(nm_q.pop_front());
    void'(exp_q.pop_front());
    void'(got_q.pop_front());
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask

  // One frame: address, read flag, data byte, MSB first
  task automatic frame(input logic [6:0] a, input logic rd, input logic [7:0] wd,
                       output logic [7:0] r);
    logic [15:0] w;
    w = {a, rd, wd};
    r = 8'h00;
    pen <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      pclk <= 1'b0;
      pdat <= w[i];
      repeat (3) @(posedge clk);
      if (i < 8) r[i] = p_do;
      if (rd && i == 0) chk("read drive", 8'h01, {7'h00, p_oe});
      pclk <= 1'b1;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    pclk <= 1'b0;
    pen <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    frame(a, 1'b0, d, r);
  endtask

  task automatic rdchk(input string nm, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    frame(a, 1'b1, 8'h00, r);
    chk(nm, e, r);
  endtask

  // Demodulator and symbol pulses, one every second cycle
  task automatic pulses(input int n, input logic u, input logic d, input logic s);
    repeat (n) begin
      @(posedge clk);
      up <= u;
      dn <= d;
      sym <= s;
      @(posedge clk);
      up <= 1'b0;
      dn <= 1'b0;
      sym <= 1'b0;
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return ph1;
      1: return ph2;
      2: return mclk;
      default: return bck;
    endcase
  endfunction

  // Cycles between two rising edges, bounded
  task automatic period(input int k, output int n);
    logic p;
    int e, c;
    p = 1'b1;
    e = 0;
    c = 0;
    n = 0;
    while (e < 2 && c < 6000) begin
      @(posedge clk);
      c++;
      n++;
      if (ph1 && ph2) ovl++;
      if (sig(k) && !p) begin
        e++;
        if (e == 1) n = 0;
      end
      p = sig(k);
    end
  endtask

  task automatic summarize;
    #1;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog well past the expected run length
  initial begin
    #(40000 * 25);
    fails++;
    summarize();
  end

  initial begin
    logic [7:0] r, e, b0, s0;
    int nu, nd, n;
    clk = 1'b0;
    arst_n = 1'b0;
    {pclk, pen, pdat, up, dn, ddat, sym, run_data} = 8'h00;
    {fails, tests_run, ovl, dcnt} = 128'h0;
    void'($urandom(32'h247d));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) rdchk("reset value", ra[i], rv[i]);
    // Filter divider, phase periods and fixed top bits
    foreach (fd[i]) begin
      wr(7'h08, fd[i]);
      rdchk("filter reg", 7'h08, {2'b11, fd[i][5:0]});
      period(0, n);
      chk("phase1 period", 8'(fx[i]), 8'(n));
      period(1, n);
      chk("phase2 period", 8'(fx[i]), 8'(n));
    end
    chk("phase overlap", 8'h00, 8'(ovl));
    // Amplifier level codes and bypass
    for (int l = 0; l < 8; l++) begin
      wr(7'h00, {1'b0, 3'(l), 4'h0});
      chk("amp on", {7'h00, 1'(l != 0)}, {7'h00, pa_on});
      chk("level", 8'(l), {5'h00, lvl});
    end
    wr(7'h02, 8'h10);
    chk("bypass", 8'h01, {7'h00, byp});
    chk("level kept", 8'h07, {5'h00, lvl});
    wr(7'h02, 8'h00);
    chk("bypass off", 8'h00, {7'h00, byp});
    wr(7'h00, 8'h80);
    chk("lna skip", 8'h01, {7'h00, lna});
    wr(7'h01, 8'h08);
    chk("rssi enable", 8'h01, {7'h00, rssi});
    // Error estimator: each symbol count, last counted pulse, then hold
    for (int c = 0; c < 4; c++) begin
      wr(7'h15, {4'h0, 2'(c), 2'b11});
      nu = $urandom_range(20);
      nd = $urandom_range(20);
      pulses(nu, 1'b1, 1'b0, 1'b0);
      pulses(nd, 1'b0, 1'b1, 1'b0);
      pulses(2, 1'b1, 1'b1, 1'b0);
      pulses((8 << c) - 1, 1'b0, 1'b0, 1'b1);
      pulses(1, 1'b1, 1'b0, 1'b0);
      pulses(1, 1'b0, 1'b0, 1'b1);
      pulses(3, 1'b1, 1'b0, 1'b0);
      rdchk("error value", 7'h16, 8'(nu - nd + 1));
    end
    wr(7'h15, 8'h0C);
    pulses(5, 1'b1, 1'b0, 1'b0);
    rdchk("error off", 7'h16, 8'h00);
    wr(7'h15, 8'h0F);
    pulses(130, 1'b1, 1'b0, 1'b0);
    frame(7'h16, 1'b1, 8'h00, r);
    chk("wrapped value", 8'h82, r);
    chk("negated size", 8'h7E, r[7] ? 8'(-r) : r);
    wr(7'h01, 8'h00);
    rdchk("cleared on load", 7'h16, 8'h00);
    // Shared reference divider, modulator tick
    wr(7'h07, 8'h02);
    wr(7'h06, 8'h7E);
    period(2, n);
    chk("mod tick s7", 8'h02, 8'(n));
    wr(7'h06, 8'h5E);
    period(2, n);
    chk("mod tick s5", 8'h08, 8'(n));
    // Bit synchronizer in receive mode
    wr(7'h00, 8'h0C);
    chk("clock pin drive", 8'h01, {7'h00, bck_oe});
    chk("data pin drive", 8'h01, {7'h00, sd_oe});
    period(3, n);
    chk("data clock period", 8'h20, 8'(n));
    run_data <= 1'b1;
    n = 0;
    while (lock !== 1'b1 && n < 22 * 32) begin
      @(posedge clk);
      n++;
    end
    chk("lock in time", 8'h01, {7'h00, lock});
    b0 = bad;
    s0 = smp;
    repeat (8 * 32) @(posedge clk);
    chk("change edge", b0, bad);
    chk("falling samples", 8'h01, {7'h00, 1'((smp - s0) >= 8'h08)});
    chk("alternating", 8'h01, {7'h00, lb[1] ^ lb[0]});
    run_data <= 1'b0;
    wr(7'h06, 8'h5C);
    period(3, n);
    chk("data clock s6", 8'h40, 8'(n));
    wr(7'h00, 8'h04);
    chk("clock pin off", 8'h00, {7'h00, bck_oe});
    // Transparent receive loops back through the pin into the transmit sampler
    ddat <= ~ddat;
    repeat (3) @(posedge clk);
    chk("tx data", {7'h00, ddat}, {7'h00, txd});
    wait (got_q.size() == 0);
    summarize();
  end
endmodule
`default_nettype wire
